/* File: src/fcf_pkg.sv */
package fcf_pkg;
  // frame control field geometry
  localparam int FCTL_W  = 24;
  localparam int B_XCTX  = 23;
  localparam int B_SCTX  = 22;
  localparam int B_FIRST = 21;
  localparam int B_LAST  = 20;
  localparam int B_END   = 19;
  localparam int B_PRIO  = 17;
  localparam int B_SI    = 16;
  localparam int ACK_HI  = 13;
  localparam int ACK_LO  = 12;
  localparam int OBS_HI  = 9;
  localparam int OBS_LO  = 6;
  localparam int POL_HI  = 5;
  localparam int POL_LO  = 4;
  localparam int W1_HI   = 31;
  localparam int W1_LO   = 24;

  // acknowledgement form codes
  localparam logic [1:0] ACK_NONE = 2'h0;
  localparam logic [1:0] ACK_ONE  = 2'h1;
  localparam logic [1:0] ACK_RSV  = 2'h2;
  localparam logic [1:0] ACK_ALL  = 2'h3;

  // error policy codes
  localparam logic [1:0] POL_MULTI  = 2'h0;
  localparam logic [1:0] POL_SINGLE = 2'h1;
  localparam logic [1:0] POL_INF    = 2'h2;
  localparam logic [1:0] POL_OBS    = 2'h3;

  // register map, byte addresses
  localparam int          AW        = 4;
  localparam logic [3:0]  ADDR_CTRL = 4'h0;
  localparam logic [3:0]  ADDR_STAT = 4'h4;
  localparam logic [3:0]  ADDR_REJ  = 4'h8;
  localparam logic [6:0]  CTRL_RST  = 7'h00;
  localparam logic [15:0] REJ_RST   = 16'h0000;

  // control register fields
  localparam int C_POL_LO = 0;
  localparam int C_POL_HI = 1;
  localparam int C_PRIO   = 2;
  localparam int C_ACK_LO = 3;
  localparam int C_ACK_HI = 4;
  localparam int C_CLS3   = 5;
  localparam int C_INFNEG = 6;

  typedef enum logic [1:0] {
    XS_IDLE = 2'b00,
    XS_OPEN = 2'b01,
    XS_DONE = 2'b10
  } fcf_xstate_t;
endpackage

/* File: src/fcf_dlv_if.sv */
`timescale 1ns/1ps
interface fcf_dlv_if;
  logic       data_vld;
  logic       end_seq;
  logic [1:0] policy;
  logic       seq_bad;
  logic       abts_done;
  logic       deliver_seq;
  logic       deliver_frame;
  logic       discarding;
  modport src (output data_vld, end_seq, policy, seq_bad, abts_done,
               input deliver_seq, deliver_frame, discarding);
  modport dst (input data_vld, end_seq, policy, seq_bad, abts_done,
               output deliver_seq, deliver_frame, discarding);
endinterface

/* File: src/fcf_dlv.sv */
`timescale 1ns/1ps
module fcf_dlv (
  input wire logic clk_i,
  input wire logic rst_i,
  fcf_dlv_if.dst   d
);
  import fcf_pkg::*;

  logic discard_q;
  logic seq_q;
  logic frame_q;
  wire  seq_ok    = d.data_vld & d.end_seq & ~d.seq_bad;
  wire  seq_fail  = d.data_vld & d.end_seq & d.seq_bad;
  wire  is_multi  = (d.policy == POL_MULTI);
  wire  is_single = (d.policy == POL_SINGLE);
  wire  is_inf    = (d.policy == POL_INF);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      discard_q <= 1'b0;
      seq_q     <= 1'b0;
      frame_q   <= 1'b0;
    end else begin
      // failure wins over abort completion in the same cycle
      if (is_multi && seq_fail) begin
        discard_q <= 1'b1;
      end else if (d.abts_done) begin
        discard_q <= 1'b0;
      end
      seq_q   <= seq_ok & ((is_multi & ~discard_q) | is_single);
      frame_q <= is_inf & d.data_vld;
    end
  end

  assign d.deliver_seq   = seq_q;
  assign d.deliver_frame = frame_q;
  assign d.discarding    = discard_q;
endmodule

/* File: src/fcf_top.sv */
// Design decisions made here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module fcf_top (
  // clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  // register bus
  input  wire logic [fcf_pkg::AW-1:0]     avs_address_i,
  input  wire logic                       avs_read_i,
  input  wire logic                       avs_write_i,
  input  wire logic [31:0]                avs_writedata_i,
  output logic      [31:0]                avs_readdata_o,
  output logic                            avs_waitrequest_o,
  // transmit request
  input  wire logic                       tx_open_i,
  input  wire logic                       tx_req_i,
  input  wire logic                       tx_is_data_i,
  input  wire logic                       tx_end_seq_i,
  input  wire logic                       tx_last_seq_i,
  input  wire logic                       tx_pass_init_i,
  output logic      [fcf_pkg::FCTL_W-1:0] tx_fctl_o,
  output logic                            tx_valid_o,
  output logic                            tx_may_send_o,
  // received header
  input  wire logic                       rx_valid_i,
  input  wire logic [31:0]                rx_word1_i,
  input  wire logic [31:0]                rx_word2_i,
  input  wire logic                       rx_is_data_i,
  input  wire logic                       rx_is_ack_i,
  input  wire logic                       rx_is_busy_i,
  input  wire logic                       rx_class3_i,
  input  wire logic                       rx_seq_bad_i,
  input  wire logic                       abts_done_i,
  // decoded receive flags
  output logic                            rx_from_resp_o,
  output logic                            rx_from_recip_o,
  output logic                            rx_first_seq_o,
  output logic                            rx_last_seq_o,
  output logic                            rx_end_seq_o,
  output logic                            rx_cs_ctl_vld_o,
  output logic                            rx_prio_vld_o,
  output logic      [7:0]                 rx_ctl_byte_o,
  output logic                            rx_si_pass_o,
  output logic                            rx_ack_form_vld_o,
  output logic      [1:0]                 rx_ack_form_o,
  output logic                            rx_policy_vld_o,
  output logic      [1:0]                 rx_policy_o,
  output logic                            busy_on_data_o,
  output logic                            busy_on_ack_o,
  output logic                            reject_o,
  // delivery
  output logic                            deliver_seq_o,
  output logic                            deliver_frame_o,
  output logic                            discarding_o
);
  import fcf_pkg::*;

  fcf_dlv_if dl ();

  // register state
  logic [6:0]  ctrl_q;
  logic [15:0] rej_cnt_q;
  logic        ack_q;
  logic [31:0] rdata_q;

  // exchange and sequence state
  fcf_xstate_t xs_q;
  fcf_xstate_t xs_d;
  logic        orig_q;
  logic        init_q;
  logic        pend_q;
  logic        first_q;
  logic        seq_open_q;
  logic        prio_q;
  logic        last_q;
  logic        rx_seen_q;
  logic [1:0]  xpol_q;
  logic        cp_last_q;
  logic        cp_end_q;
  logic        cp_si_q;
  logic [23:0] fctl_q;
  logic        tvalid_q;

  // register bus decode
  wire bus_req  = avs_read_i | avs_write_i;
  wire bus_go   = bus_req & ack_q;
  wire wr_ctrl  = bus_go & avs_write_i & (avs_address_i == ADDR_CTRL);
  wire sel_ctrl = (avs_address_i == ADDR_CTRL);
  wire sel_stat = (avs_address_i == ADDR_STAT);
  wire sel_rej  = (avs_address_i == ADDR_REJ);

  wire [1:0] cfg_pol  = ctrl_q[C_POL_HI:C_POL_LO];
  wire [1:0] cfg_ack  = ctrl_q[C_ACK_HI:C_ACK_LO];
  wire       cfg_cls3 = ctrl_q[C_CLS3];
  wire       cfg_inf  = ctrl_q[C_INFNEG];

  // receive decode, same cycle as capture
  wire [23:0] rf      = rx_word2_i[FCTL_W-1:0];
  wire        rx_dat  = rx_valid_i & rx_is_data_i;
  wire        rx_ack  = rx_valid_i & rx_is_ack_i;
  wire        rx_c2   = ~rx_class3_i;
  wire        rx_endb = rf[B_END];
  wire        rx_xfirst = rx_dat & rf[B_FIRST] & ~rx_seen_q;
  // the exchange's first frame carries the policy that counts, as does any class 3 first-sequence frame
  wire        pol_vld = rx_dat & (rx_xfirst | (rx_class3_i & rf[B_FIRST]));
  wire [1:0]  rx_pol  = rf[POL_HI:POL_LO];
  wire [1:0]  rx_ackf = rf[ACK_HI:ACK_LO];
  wire        ackf_vld = rx_dat & rx_c2;
  wire        bad_ackf = ackf_vld & (rx_ackf == ACK_RSV);
  wire        bad_pol  = rx_dat & rx_c2 & rx_xfirst &
                         ((rx_pol == POL_INF) | (rx_pol == POL_OBS));
  wire        bad_obs  = rx_valid_i & (rf[OBS_HI:OBS_LO] != 4'h0);
  wire        rej      = rx_valid_i & rx_c2 & (bad_ackf | bad_pol | bad_obs);
  wire        rx_si    = rx_endb & rf[B_SI];

  assign rx_from_resp_o    = rx_valid_i & rf[B_XCTX];
  assign rx_from_recip_o   = rx_valid_i & rf[B_SCTX];
  assign rx_first_seq_o    = rx_valid_i & rf[B_FIRST];
  assign rx_last_seq_o     = rx_dat & rf[B_LAST];
  assign rx_end_seq_o      = (rx_dat | rx_ack) & rx_endb;
  assign rx_cs_ctl_vld_o   = rx_valid_i & ~rf[B_PRIO];
  assign rx_prio_vld_o     = rx_valid_i & rf[B_PRIO];
  assign rx_ctl_byte_o     = rx_word1_i[W1_HI:W1_LO];
  assign rx_si_pass_o      = (rx_dat | rx_ack) & rx_si;
  assign rx_ack_form_vld_o = ackf_vld & ~bad_ackf;
  assign rx_ack_form_o     = ackf_vld ? rx_ackf : ACK_NONE;
  assign rx_policy_vld_o   = pol_vld;
  assign rx_policy_o       = pol_vld ? rx_pol : POL_MULTI;
  // busy sent from the recipient side answers our data frame
  assign busy_on_data_o    = rx_valid_i & rx_is_busy_i & rx_c2 & rf[B_SCTX];
  assign busy_on_ack_o     = rx_valid_i & rx_is_busy_i & rx_c2 & ~rf[B_SCTX];
  assign reject_o          = rej;

  // transmit field assembly
  wire       tx_dat    = tx_req_i & tx_is_data_i;
  wire       tx_lc     = tx_req_i & ~tx_is_data_i;
  wire       seq_prio  = seq_open_q ? prio_q : ctrl_q[C_PRIO];
  wire       last_now  = last_q | tx_last_seq_i;
  wire       tx_xfirst = first_q & ~seq_open_q & init_q & orig_q & ~pend_q;
  // obsolete code coerced, infinite-buffer only in class 3
  wire [1:0] safe_pol  = (cfg_pol == POL_OBS) ? POL_MULTI :
                         ((cfg_pol == POL_INF) & ~cfg_cls3) ? POL_MULTI : cfg_pol;
  wire       send_pol  = tx_xfirst | (cfg_cls3 & cfg_inf & (xpol_q == POL_INF));
  wire [1:0] tx_pol    = ~send_pol ? POL_MULTI : (tx_xfirst ? safe_pol : xpol_q);
  // reserved ack form never leaves the port
  wire [1:0] tx_ackf   = (cfg_cls3 | (cfg_ack == ACK_RSV)) ? ACK_NONE : cfg_ack;
  wire       tx_end_d  = tx_dat & tx_end_seq_i;
  wire       tx_si_d   = tx_end_d & tx_pass_init_i;

  wire [23:0] data_fctl = {~orig_q, 1'b0, first_q, last_now, tx_end_seq_i, 1'b0, seq_prio,
                           tx_si_d, 2'h0, tx_ackf, 6'h00, tx_pol, 4'h0};
  wire [23:0] lc_fctl   = {~orig_q, 1'b1, first_q, cp_last_q, cp_end_q, 1'b0, prio_q,
                           cp_si_q, 2'h0, ACK_NONE, 6'h00, POL_MULTI, 4'h0};

  // exchange state machine
  wire rx_close = rx_dat & rf[B_LAST] & rx_endb;
  wire tx_close = tx_end_d & last_now;
  wire rx_open  = rx_xfirst & ~rf[B_XCTX];
  always_comb begin
    xs_d = xs_q;
    case (xs_q)
      XS_IDLE: begin
        if (tx_open_i || rx_open) begin
          xs_d = XS_OPEN;
        end
      end
      XS_OPEN: begin
        if (tx_close || rx_close) begin
          xs_d = XS_DONE;
        end
      end
      XS_DONE: xs_d = XS_IDLE;
      default: xs_d = XS_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      xs_q   <= XS_IDLE;
      orig_q <= 1'b1;
      init_q <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      xs_q <= xs_d;
      if (xs_q == XS_IDLE && tx_open_i) begin
        orig_q <= 1'b1;
        init_q <= 1'b1;
        pend_q <= 1'b0;
      end else if (xs_q == XS_IDLE && rx_open) begin
        orig_q <= 1'b0;
        init_q <= 1'b0;
        pend_q <= 1'b0;
      end else begin
        if (tx_si_d && cfg_cls3) begin
          init_q <= 1'b0;
        end else if (tx_si_d) begin
          pend_q <= 1'b1;
        end else if (pend_q && rx_ack && rx_si) begin
          init_q <= 1'b0;
          pend_q <= 1'b0;
        end else if (rx_dat && rx_si) begin
          init_q <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      first_q    <= 1'b0;
      seq_open_q <= 1'b0;
      prio_q     <= 1'b0;
      last_q     <= 1'b0;
      rx_seen_q  <= 1'b0;
      xpol_q     <= POL_MULTI;
    end else begin
      if (xs_q == XS_IDLE && (tx_open_i || rx_open)) begin
        first_q <= 1'b1;
      end else if (tx_end_d || (rx_dat && rx_endb)) begin
        first_q <= 1'b0;
      end
      if (tx_dat && tx_xfirst) begin
        xpol_q <= safe_pol;
      end else if (pol_vld) begin
        xpol_q <= rx_pol;
      end
      if (tx_end_d) begin
        seq_open_q <= 1'b0;
        last_q     <= 1'b0;
      end else if (tx_dat) begin
        seq_open_q <= 1'b1;
        last_q     <= last_now;
      end
      if (tx_dat && !seq_open_q) begin
        prio_q <= ctrl_q[C_PRIO];
      end
      if (xs_q == XS_DONE) begin
        rx_seen_q <= 1'b0;
      end else if (rx_dat) begin
        rx_seen_q <= 1'b1;
      end
    end
  end

  // link control echo and transmit output
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cp_last_q <= 1'b0;
      cp_end_q  <= 1'b0;
      cp_si_q   <= 1'b0;
      fctl_q    <= 24'h000000;
      tvalid_q  <= 1'b0;
    end else begin
      if (rx_dat) begin
        cp_last_q <= rf[B_LAST];
        cp_end_q  <= rx_endb;
        cp_si_q   <= rx_si;
      end
      tvalid_q <= tx_req_i;
      if (tx_dat) begin
        fctl_q <= data_fctl;
      end else if (tx_lc) begin
        fctl_q <= lc_fctl;
      end
    end
  end

  // register bus: one wait cycle, write commits when waitrequest is low
  wire [31:0] stat_word = {24'h000000, xpol_q, pend_q, dl.discarding, last_q,
                           first_q, init_q, orig_q};
  wire [31:0] rd_mux = sel_ctrl ? {25'h0000000, ctrl_q} :
                       sel_stat ? stat_word :
                       sel_rej  ? {16'h0000, rej_cnt_q} : 32'h00000000;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_q     <= 1'b0;
      rdata_q   <= 32'h00000000;
      ctrl_q    <= CTRL_RST;
      rej_cnt_q <= REJ_RST;
    end else begin
      ack_q <= bus_req & ~ack_q;
      if (bus_req && !ack_q) begin
        rdata_q <= rd_mux;
      end
      if (wr_ctrl) begin
        ctrl_q <= avs_writedata_i[6:0];
      end
      if (rej && rej_cnt_q != 16'hffff) begin
        rej_cnt_q <= rej_cnt_q + 16'h0001;
      end
    end
  end

  assign avs_waitrequest_o = bus_req & ~ack_q;
  assign avs_readdata_o    = rdata_q;
  assign tx_fctl_o         = fctl_q;
  assign tx_valid_o        = tvalid_q;
  assign tx_may_send_o     = init_q & ~pend_q & (xs_q == XS_OPEN);

  // delivery policy engine
  assign dl.data_vld  = rx_dat;
  assign dl.end_seq   = rx_endb;
  assign dl.policy    = xpol_q;
  assign dl.seq_bad   = rx_seq_bad_i;
  assign dl.abts_done = abts_done_i;

  fcf_dlv u_dlv (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d     (dl)
  );

  assign deliver_seq_o   = dl.deliver_seq;
  assign deliver_frame_o = dl.deliver_frame;
  assign discarding_o    = dl.discarding;
endmodule

/* File: tb/fcf_top_chk.sv */
`timescale 1ns/1ps
module fcf_top_chk (
  // clock and reset
  input wire logic                       clk_i,
  input wire logic                       rst_i,
  // transmit
  input wire logic                       tx_req_i,
  input wire logic                       tx_is_data_i,
  input wire logic                       tx_end_seq_i,
  input wire logic                       tx_last_seq_i,
  input wire logic [fcf_pkg::FCTL_W-1:0] tx_fctl_o,
  input wire logic                       tx_valid_o,
  // receive
  input wire logic                       rx_valid_i,
  input wire logic [31:0]                rx_word1_i,
  input wire logic [31:0]                rx_word2_i,
  input wire logic                       rx_is_data_i,
  input wire logic                       rx_is_ack_i,
  input wire logic                       rx_is_busy_i,
  input wire logic                       rx_class3_i,
  input wire logic                       rx_from_resp_o,
  input wire logic                       rx_from_recip_o,
  input wire logic                       rx_cs_ctl_vld_o,
  input wire logic                       rx_prio_vld_o,
  input wire logic [7:0]                 rx_ctl_byte_o,
  input wire logic                       rx_si_pass_o,
  input wire logic                       rx_ack_form_vld_o,
  input wire logic                       busy_on_data_o,
  input wire logic                       busy_on_ack_o,
  input wire logic                       reject_o
);
  import fcf_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_dat;
    tx_req_i && tx_is_data_i;
  endsequence
  property p_tx_mid;
    s_dat ##0 !tx_end_seq_i |=> tx_valid_o && !tx_fctl_o[B_END];
  endproperty
  property p_tx_fin;
    s_dat ##0 tx_end_seq_i |=> tx_valid_o && tx_fctl_o[B_END];
  endproperty
  property p_tx_last;
    s_dat ##0 tx_last_seq_i |=> tx_fctl_o[B_LAST];
  endproperty
  property p_tx_lc;
    tx_req_i && !tx_is_data_i |=> tx_valid_o && tx_fctl_o[B_SCTX];
  endproperty
  property p_ctx;
    rx_valid_i |-> rx_from_resp_o == rx_word2_i[B_XCTX] && rx_from_recip_o == rx_word2_i[B_SCTX];
  endproperty
  property p_busy;
    rx_valid_i && rx_is_busy_i && !rx_class3_i |->
      busy_on_data_o == rx_word2_i[B_SCTX] && busy_on_ack_o != rx_word2_i[B_SCTX];
  endproperty
  property p_ctl;
    rx_valid_i |-> rx_prio_vld_o == rx_word2_i[B_PRIO] && rx_cs_ctl_vld_o != rx_prio_vld_o
      && rx_ctl_byte_o == rx_word1_i[W1_HI:W1_LO];
  endproperty
  property p_si;
    rx_valid_i && (rx_is_data_i || rx_is_ack_i) |->
      rx_si_pass_o == (rx_word2_i[B_SI] && rx_word2_i[B_END]);
  endproperty
  property p_ackf;
    rx_valid_i && (rx_class3_i || !rx_is_data_i) |-> !rx_ack_form_vld_o;
  endproperty
  property p_rsv;
    rx_valid_i && rx_is_data_i && !rx_class3_i && rx_word2_i[ACK_HI:ACK_LO] == ACK_RSV
      |-> reject_o && !rx_ack_form_vld_o;
  endproperty
  property p_c3;
    rx_valid_i && rx_class3_i |-> !reject_o;
  endproperty
  a_tx_mid: assert property (p_tx_mid) else $error("end bit on inner frame");
  a_tx_fin: assert property (p_tx_fin) else $error("end bit missing");
  a_tx_last: assert property (p_tx_last) else $error("last bit missing");
  a_tx_lc: assert property (p_tx_lc) else $error("link frame context");
  a_ctx: assert property (p_ctx) else $error("context decode");
  a_busy: assert property (p_busy) else $error("busy context decode");
  a_ctl: assert property (p_ctl) else $error("word 1 byte select");
  a_si: assert property (p_si) else $error("initiative decode");
  a_ackf: assert property (p_ackf) else $error("ack form qualified");
  a_rsv: assert property (p_rsv) else $error("reserved ack form");
  a_c3: assert property (p_c3) else $error("class 3 reject");
endmodule
bind fcf_top fcf_top_chk fcf_top_chk_i (.clk_i, .rst_i, .tx_req_i, .tx_is_data_i,
  .tx_end_seq_i, .tx_last_seq_i, .tx_fctl_o, .tx_valid_o, .rx_valid_i, .rx_word1_i,
  .rx_word2_i, .rx_is_data_i, .rx_is_ack_i, .rx_is_busy_i, .rx_class3_i, .rx_from_resp_o,
  .rx_from_recip_o, .rx_cs_ctl_vld_o, .rx_prio_vld_o, .rx_ctl_byte_o, .rx_si_pass_o,
  .rx_ack_form_vld_o, .busy_on_data_o, .busy_on_ack_o, .reject_o);

/* File: tb/fcf_peer.sv */
`timescale 1ns/1ps
module fcf_peer (
  // clock
  input  wire logic   clk_i,
  // header toward the port
  output logic        rx_valid_o,
  output logic [31:0] rx_word1_o,
  output logic [31:0] rx_word2_o,
  output logic [3:0]  rx_kind_o,
  output logic        rx_seq_bad_o
);
  initial begin
    rx_valid_o = 1'b0;
    rx_word1_o = 32'h0;
    rx_word2_o = 32'h0;
    rx_kind_o = 4'h0;
    rx_seq_bad_o = 1'b0;
  end
  // o: peer originated the exchange, i: peer holds the initiative
  task automatic send(input logic o, i, input logic [23:0] fc, input logic [7:0] b,
                      input logic [3:0] k, input logic bad);
    rx_valid_o <= 1'b1;
    rx_word1_o <= {b, 24'h000000};
    rx_word2_o <= {8'h00, ~o, ~i, fc[21:19], 1'b0, fc[17],
                   fc[16] & fc[19], 2'h0, fc[13:12], 6'h00, fc[5:4], 4'h0};
    rx_kind_o <= k;
    rx_seq_bad_o <= bad;
    @(negedge clk_i);
  endtask
  // released lines flip so stale values never look valid
  task automatic rel();
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_word1_o <= ~rx_word1_o;
    rx_word2_o <= ~rx_word2_o;
    rx_kind_o <= 4'h0;
    rx_seq_bad_o <= 1'b0;
  endtask
endmodule

/* File: tb/fcf_top_bench.sv */
`timescale 1ns/1ps
module fcf_top_bench;
  import fcf_pkg::*;
  logic        clk_i, rst_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [3:0]  avs_address_i, rx_kind;
  logic [31:0] avs_writedata_i, avs_readdata_o, rx_word1_i, rx_word2_i, q;
  logic        tx_open_i, tx_req_i, tx_is_data_i, tx_end_seq_i, tx_last_seq_i;
  logic        tx_pass_init_i, tx_valid_o, tx_may_send_o, rx_valid_i, rx_seq_bad_i;
  logic [23:0] tx_fctl_o, f;
  logic        abts_done_i, rx_from_resp_o, rx_last_seq_o, rx_cs_ctl_vld_o;
  logic        rx_prio_vld_o, rx_si_pass_o, rx_ack_form_vld_o, rx_policy_vld_o;
  logic        busy_on_data_o, busy_on_ack_o, reject_o, deliver_seq_o, discarding_o;
  logic        rx_first_seq_o, rx_end_seq_o, deliver_frame_o;
  logic [7:0]  rx_ctl_byte_o;
  logic [1:0]  rx_policy_o, rx_ack_form_o;
  int          err_total, check_count;

  fcf_top fcf_top_i (.clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .tx_open_i, .tx_req_i,
    .tx_is_data_i, .tx_end_seq_i, .tx_last_seq_i, .tx_pass_init_i, .tx_fctl_o, .tx_valid_o,
    .tx_may_send_o, .rx_valid_i, .rx_word1_i, .rx_word2_i, .rx_is_data_i(rx_kind[3]),
    .rx_is_ack_i(rx_kind[2]), .rx_is_busy_i(rx_kind[1]), .rx_class3_i(rx_kind[0]),
    .rx_seq_bad_i, .abts_done_i, .rx_from_resp_o, .rx_from_recip_o(), .rx_first_seq_o,
    .rx_last_seq_o, .rx_end_seq_o, .rx_cs_ctl_vld_o, .rx_prio_vld_o, .rx_ctl_byte_o,
    .rx_si_pass_o, .rx_ack_form_vld_o, .rx_ack_form_o, .rx_policy_vld_o, .rx_policy_o,
    .busy_on_data_o, .busy_on_ack_o, .reject_o, .deliver_seq_o, .deliver_frame_o,
    .discarding_o);
  fcf_peer fcf_peer_i (.clk_i, .rx_valid_o(rx_valid_i), .rx_word1_o(rx_word1_i),
    .rx_word2_o(rx_word2_i), .rx_kind_o(rx_kind), .rx_seq_bad_o(rx_seq_bad_i));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic end_sim();
    if (err_total == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // request held until the edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0) begin
      n++;
      if (n > 20) begin
        err_total++;
        end_sim();
      end
      @(posedge clk_i);
    end
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, q, e);
  endtask
  task automatic txf(input logic dat, en, ls, ps);
    tx_req_i <= 1'b1;
    tx_is_data_i <= dat;
    tx_end_seq_i <= en;
    tx_last_seq_i <= ls;
    tx_pass_init_i <= ps;
    @(posedge clk_i);
    tx_req_i <= 1'b0;
    @(negedge clk_i);
    chk("tx_valid", tx_valid_o, 1'b1);
    f = tx_fctl_o;
    @(posedge clk_i);
  endtask
  task automatic opn();
    tx_open_i <= 1'b1;
    @(posedge clk_i);
    tx_open_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic dl(input logic e);
    fcf_peer_i.rel();
    @(negedge clk_i);
    chk("deliver_seq", deliver_seq_o, e);
    @(posedge clk_i);
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    end_sim();
  end
  initial begin
    {avs_address_i, avs_read_i, avs_write_i, avs_writedata_i} = '0;
    {tx_open_i, tx_req_i, tx_is_data_i, tx_end_seq_i, tx_last_seq_i, tx_pass_init_i} = '0;
    abts_done_i = 1'b0;
    err_total = 0;
    check_count = 0;
    rst_i = 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc(ADDR_REJ, 32'h0, "rej_reset");
    bus(1'b1, ADDR_CTRL, 32'hffff_ffff);
    rdc(ADDR_CTRL, 32'h7f, "ctrl_rw");
    bus(1'b1, 4'hc, 32'h1);
    rdc(4'hc, 32'h0, "unmapped");
    bus(1'b1, ADDR_CTRL, 32'h0d);
    opn();
    chk("may_send", tx_may_send_o, 1'b1);
    txf(1'b1, 1'b0, 1'b0, 1'b0);
    chk("tx_xctx", f[B_XCTX], 1'b0);
    chk("tx_sctx", f[B_SCTX], 1'b0);
    chk("tx_first", f[B_FIRST], 1'b1);
    chk("tx_ackf", f[ACK_HI:ACK_LO], ACK_ONE);
    chk("tx_pol", f[POL_HI:POL_LO], POL_SINGLE);
    txf(1'b1, 1'b1, 1'b0, 1'b1);
    chk("tx_si", f[B_SI], 1'b1);
    chk("tx_prio", f[B_PRIO], 1'b1);
    chk("si_pending", tx_may_send_o, 1'b0);
    rdc(ADDR_STAT, 32'h63, "stat_pend");
    fcf_peer_i.send(1'b0, 1'b0, 24'h290000, 8'h00, 4'b0100, 1'b0);
    chk("rx_resp", rx_from_resp_o, 1'b1);
    chk("rx_end", rx_end_seq_o, 1'b1);
    chk("rx_si", rx_si_pass_o, 1'b1);
    dl(1'b0);
    chk("si_gone", tx_may_send_o, 1'b0);
    fcf_peer_i.send(1'b0, 1'b1, 24'h100000, 8'h00, 4'b1000, 1'b0);
    chk("rx_last", rx_last_seq_o, 1'b1);
    dl(1'b0);
    txf(1'b0, 1'b0, 1'b0, 1'b0);
    chk("lc_last", f[B_LAST], 1'b1);
    chk("lc_sctx", f[B_SCTX], 1'b1);
    chk("lc_first", f[B_FIRST], 1'b0);
    fcf_peer_i.send(1'b0, 1'b1, 24'h180000, 8'h00, 4'b1000, 1'b0);
    dl(1'b1);
    fcf_peer_i.send(1'b1, 1'b1, 24'h200000, 8'h00, 4'b1000, 1'b0);
    chk("pol_vld", rx_policy_vld_o, 1'b1);
    chk("rx_first", rx_first_seq_o, 1'b1);
    chk("pol", rx_policy_o, POL_MULTI);
    dl(1'b0);
    fcf_peer_i.send(1'b1, 1'b1, 24'h280000, 8'h00, 4'b1000, 1'b1);
    dl(1'b0);
    chk("discard_on", discarding_o, 1'b1);
    fcf_peer_i.send(1'b1, 1'b1, 24'h280000, 8'h00, 4'b1000, 1'b0);
    dl(1'b0);
    abts_done_i <= 1'b1;
    @(posedge clk_i);
    abts_done_i <= 1'b0;
    @(posedge clk_i);
    chk("discard_off", discarding_o, 1'b0);
    fcf_peer_i.send(1'b1, 1'b1, 24'h280000, 8'h00, 4'b1000, 1'b0);
    dl(1'b1);
    fcf_peer_i.send(1'b1, 1'b1, 24'h202000, 8'h00, 4'b1000, 1'b0);
    chk("rej_rsv", reject_o, 1'b1);
    chk("pol_later", rx_policy_vld_o, 1'b0);
    fcf_peer_i.rel();
    rdc(ADDR_REJ, 32'h1, "rej_count");
    fcf_peer_i.send(1'b1, 1'b1, 24'h203020, 8'h00, 4'b1001, 1'b0);
    chk("c3_ackf", rx_ack_form_vld_o, 1'b0);
    chk("c3_ackf_code", rx_ack_form_o, ACK_NONE);
    fcf_peer_i.rel();
    fcf_peer_i.send(1'b1, 1'b0, 24'h200000, 8'h00, 4'b0010, 1'b0);
    chk("busy_data", busy_on_data_o, 1'b1);
    fcf_peer_i.rel();
    fcf_peer_i.send(1'b1, 1'b1, 24'h200000, 8'h00, 4'b0010, 1'b0);
    chk("busy_ack", busy_on_ack_o, 1'b1);
    fcf_peer_i.rel();
    fcf_peer_i.send(1'b1, 1'b1, 24'h220020, 8'h5a, 4'b1001, 1'b0);
    chk("prio_byte", rx_ctl_byte_o, 8'h5a);
    chk("cs_ctl", rx_cs_ctl_vld_o, 1'b0);
    fcf_peer_i.rel();
    @(negedge clk_i);
    chk("deliver_frame", deliver_frame_o, 1'b1);
    @(posedge clk_i);
    fcf_peer_i.send(1'b1, 1'b1, 24'h380000, 8'h00, 4'b1000, 1'b0);
    fcf_peer_i.rel();
    bus(1'b1, ADDR_CTRL, 32'h03);
    opn();
    txf(1'b1, 1'b1, 1'b1, 1'b0);
    chk("tx_last", f[B_LAST], 1'b1);
    chk("obs_pol", f[POL_HI:POL_LO], POL_MULTI);
    chk("tx_first2", f[B_FIRST], 1'b1);
    end_sim();
  end
endmodule
